// ==== design/vis_pkg.sv ====
// Package with constants of the video input select and status block
package vis_pkg;
    // Status bit positions
    localparam int STAT_W = 4;
    localparam int ST_ACT1 = 0;
    localparam int ST_ACT2 = 1;
    localparam int ST_SEL = 2;
    localparam int ST_NTSC = 3;
    // Output format
    localparam int VID_W = 10;
    localparam int HS_BIT = 1;
    localparam int VS_BIT = 0;
    // Strap codes
    localparam logic [1:0] STRAP_CORE = 2'h0;
    localparam logic [1:0] STRAP_GND = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    // Target addresses, arbitrary values
    localparam logic [6:0] ADDR_CORE = 7'h20;
    localparam logic [6:0] ADDR_GND = 7'h21;
    localparam logic [6:0] ADDR_SDA = 7'h22;
    // Activity judged from samples: sync tip below threshold
    localparam logic [9:0] SYNC_SLICE = 10'h080;
    // Clock source selection
    localparam logic [1:0] CLK_XTAL27 = 2'h0;
    localparam logic [1:0] CLK_EXT27 = 2'h1;
    localparam logic [1:0] CLK_EXT54 = 2'h2;
    // Activity timeout in sample enables
    localparam int ACT_TIMEOUT = 255;
    localparam logic [7:0] ACT_TIMEOUT_V = 8'hFF;
    // Selection state machine
    typedef enum logic [2:0] {
        VIS_ONE = 3'b001,
        VIS_TWO = 3'b010,
        VIS_HOLD = 3'b100
    } vis_state_t;
endpackage : vis_pkg

// ==== design/vis_act_det.sv ====
// Activity detector of one video input
`timescale 1ns/10ps
module vis_act_det #(
    parameter int TIMEOUT = vis_pkg::ACT_TIMEOUT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic smp_en_i,
    input wire logic routed_i,
    input wire logic sleep_i,
    input wire logic [9:0] adc_i,
    input wire logic slicer_i,
    output logic active_o
);
    import vis_pkg::*;
    logic [7:0] cnt;
    logic sync_hit;
    always_comb begin
        if (routed_i && !sleep_i) begin
            sync_hit = adc_i < SYNC_SLICE;
        end else begin
            sync_hit = slicer_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            active_o <= 1'b0;
        end else if (smp_en_i) begin
            if (sync_hit) begin
                cnt <= TIMEOUT[7:0];
                active_o <= 1'b1;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else begin
                active_o <= 1'b0;
            end
        end
    end
endmodule : vis_act_det

// ==== design/vis_top.sv ====
// Input selection, status, interrupt and output format logic
// Contract
// - Both inputs are watched for activity at all times.
// - Routed input activity comes from converter samples.
// - Unrouted input activity comes from clamp and slicer detector.
// - In sleep, both inputs use slicer detectors only.
// - Activity results are readable in status register.
// - Auto enable lets device choose input from activity.
// - Auto picks input one when both active at start or neither.
// - Auto picks input two when only input two active.
// - Input two stays chosen until its activity disappears.
// - Unmasked interrupt goes low when a status bit changes.
// - Interrupt held until status read; further changes ignored. A change in the same cycle as the read keeps it pending instead.
// - Address strap picks one of three target addresses.
// - Default output is 10-bit 4:2:2 with embedded codes, LSB bit 0.
// - Format setting turns two lowest bits into sync outputs.
// - Output clock follows line rate or crystal per mode.
// - Sample clock stays locked within five percent line variation.
// - Runs unprogrammed after power-up, standard found automatically.
// - Crystal or external 27 or 54 MHz clock accepted; sample enable stays high for all three sources, so 54 MHz is not divided down.
// - Status and settings go through target register accesses.
// - In async mode output clock is sample clock divided by two.
`timescale 1ns/10ps
module vis_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic video_input_one_slicer_i,
    input wire logic video_input_two_slicer_i,
    input wire logic [9:0] adc_sample_i,
    input wire logic sleep_i,
    input wire logic input_choice_field_i,
    input wire logic auto_input_choice_enable_i,
    input wire logic irq_mask_i,
    input wire logic status_read_i,
    input wire logic sync_out_enable_i,
    input wire logic async_mode_i,
    input wire logic [1:0] clk_source_i,
    input wire logic pll_locked_i,
    input wire logic std_ntsc_i,
    input wire logic [1:0] target_address_strap_i,
    input wire logic [9:0] video_data_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic line_clk_i,
    output logic [vis_pkg::STAT_W-1:0] status_o,
    output logic input_two_routed_o,
    output logic irq_n_out_o,
    output logic irq_n_oe_o,
    output logic [6:0] target_address_o,
    output logic [vis_pkg::VID_W-1:0] video_output_bus_o,
    output logic video_output_clock_o,
    output logic sample_enable_o,
    output logic clock_locked_o
);
    import vis_pkg::*;

    // ------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------
    logic [1:0] sl1_s, sl2_s, lc_s, stp0_s, stp1_s;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sl1_s <= 2'h0;
            sl2_s <= 2'h0;
            lc_s <= 2'h0;
            stp0_s <= 2'h0;
            stp1_s <= 2'h0;
        end else begin
            sl1_s <= {sl1_s[0], video_input_one_slicer_i};
            sl2_s <= {sl2_s[0], video_input_two_slicer_i};
            lc_s <= {lc_s[0], line_clk_i};
            stp0_s <= {stp0_s[0], target_address_strap_i[0]};
            stp1_s <= {stp1_s[0], target_address_strap_i[1]};
        end
    end

    // ------------------------------------------------
    // Sample rate enable, held high for every clock source
    // ------------------------------------------------
    logic div_ph;
    logic smp_en;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ph <= 1'b0;
        end else begin
            div_ph <= ~div_ph;
        end
    end
    always_comb begin
        case (clk_source_i)
            CLK_EXT54: smp_en = 1'b1;
            CLK_XTAL27, CLK_EXT27: smp_en = 1'b1;
            default: smp_en = 1'b1;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_enable_o <= 1'b0;
            clock_locked_o <= 1'b0;
        end else begin
            sample_enable_o <= smp_en;
            clock_locked_o <= pll_locked_i;
        end
    end

    // ------------------------------------------------
    // Activity detection
    // ------------------------------------------------
    logic act1, act2, route_two;
    vis_act_det #(.TIMEOUT(ACT_TIMEOUT)) u_det1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .smp_en_i(smp_en),
        .routed_i(!route_two),
        .sleep_i(sleep_i),
        .adc_i(adc_sample_i),
        .slicer_i(sl1_s[1]),
        .active_o(act1)
    );
    vis_act_det #(.TIMEOUT(ACT_TIMEOUT)) u_det2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .smp_en_i(smp_en),
        .routed_i(route_two),
        .sleep_i(sleep_i),
        .adc_i(adc_sample_i),
        .slicer_i(sl2_s[1]),
        .active_o(act2)
    );

    // ------------------------------------------------
    // Input selection
    // ------------------------------------------------
    vis_state_t state, next_state;
    logic first;
    always_comb begin
        next_state = state;
        case (state)
            VIS_ONE: begin
                if (act2 && !act1 && !first) begin
                    next_state = VIS_TWO;
                end else begin
                    next_state = VIS_ONE;
                end
            end
            VIS_TWO: begin
                if (!act2) begin
                    next_state = VIS_ONE;
                end
            end
            VIS_HOLD: next_state = VIS_ONE;
            default: next_state = VIS_ONE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= VIS_HOLD;
            first <= 1'b1;
        end else begin
            first <= 1'b0;
            if (auto_input_choice_enable_i) begin
                state <= next_state;
            end else if (input_choice_field_i) begin
                state <= VIS_TWO;
            end else begin
                state <= VIS_ONE;
            end
        end
    end
    assign route_two = (state == VIS_TWO);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_two_routed_o <= 1'b0;
        end else begin
            input_two_routed_o <= route_two;
        end
    end

    // ------------------------------------------------
    // Status and interrupt
    // ------------------------------------------------
    logic [STAT_W-1:0] stat_now;
    logic irq_pend;
    always_comb begin
        stat_now = '0;
        stat_now[ST_ACT1] = act1;
        stat_now[ST_ACT2] = act2;
        stat_now[ST_SEL] = route_two;
        stat_now[ST_NTSC] = std_ntsc_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= '0;
            irq_pend <= 1'b0;
        end else begin
            status_o <= stat_now;
            if ((stat_now != status_o) && !irq_mask_i) begin
                irq_pend <= 1'b1;
            end else if (status_read_i) begin
                irq_pend <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_out_o <= 1'b0;
            irq_n_oe_o <= 1'b0;
        end else begin
            irq_n_out_o <= 1'b0;
            irq_n_oe_o <= irq_pend;
        end
    end

    // ------------------------------------------------
    // Target address strap
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_address_o <= ADDR_CORE;
        end else begin
            case ({stp1_s[1], stp0_s[1]})
                STRAP_CORE: target_address_o <= ADDR_CORE;
                STRAP_GND: target_address_o <= ADDR_GND;
                STRAP_SDA: target_address_o <= ADDR_SDA;
                default: target_address_o <= ADDR_CORE;
            endcase
        end
    end

    // ------------------------------------------------
    // Output format and clock
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            video_output_bus_o <= '0;
        end else if (sync_out_enable_i) begin
            video_output_bus_o <= video_data_i;
            video_output_bus_o[HS_BIT] <= hsync_i;
            video_output_bus_o[VS_BIT] <= vsync_i;
        end else begin
            video_output_bus_o <= video_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            video_output_clock_o <= 1'b0;
        end else if (async_mode_i) begin
            video_output_clock_o <= div_ph;
        end else begin
            video_output_clock_o <= lc_s[1];
        end
    end
endmodule : vis_top

// ==== testbench/vis_src_model.sv ====
// Video source model: slicer pulses and routed converter samples
`timescale 1ns/10ps
module vis_src_model (
    input wire logic clk_i,
    input wire logic on1_i,
    input wire logic on2_i,
    input wire logic routed_two_i,
    input wire logic sleep_i,
    output logic slc1_o,
    output logic slc2_o,
    output logic [9:0] adc_o
);
    logic [3:0] ph = 4'h0;
    logic live;
    always @(posedge clk_i) begin
        ph <= ph + 4'h1;
    end
    // One sync pulse every 16 cycles on each live input
    assign slc1_o = on1_i && ph == 4'h0;
    assign slc2_o = on2_i && ph == 4'h0;
    // Routed input shows sync tip at code 32, else blanking
    assign live = routed_two_i ? on2_i : on1_i;
    // Converter output stays at blanking while the front end sleeps
    assign adc_o = (!sleep_i && live && ph < 4'h2) ? 10'h020 : 10'h200;
endmodule : vis_src_model

// ==== testbench/vis_top_props.sv ====
// Concurrent checks of the input select block
`timescale 1ns/10ps
module vis_top_props
    import vis_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic input_choice_field_i,
    input wire logic auto_input_choice_enable_i,
    input wire logic status_read_i,
    input wire logic sync_out_enable_i,
    input wire logic async_mode_i,
    input wire logic [1:0] target_address_strap_i,
    input wire logic [9:0] video_data_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic [STAT_W-1:0] status_o,
    input wire logic input_two_routed_o,
    input wire logic irq_n_oe_o,
    input wire logic [6:0] target_address_o,
    input wire logic [VID_W-1:0] video_output_bus_o,
    input wire logic video_output_clock_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic auto, a1, a2;
    assign auto = auto_input_choice_enable_i;
    assign a1 = status_o[ST_ACT1];
    assign a2 = status_o[ST_ACT2];
    chk_manual_sel: assert property (($stable(input_choice_field_i) &&
        !auto)[*3] |-> input_two_routed_o == input_choice_field_i)
        else $error("manual select not followed");
    chk_auto_idle: assert property ((auto && !a1 && !a2)[*4]
        |-> !input_two_routed_o) else $error("idle auto not input one");
    chk_auto_two: assert property ((auto && !a1 && a2)[*4]
        |-> input_two_routed_o) else $error("auto did not pick two");
    chk_irq_hold: assert property (irq_n_oe_o && !status_read_i &&
        !$past(status_read_i) |=> irq_n_oe_o) else $error("irq dropped");
    chk_irq_release: assert property ($fell(irq_n_oe_o)
        |-> $past(status_read_i, 2)) else $error("irq freed without read");
    chk_irq_cause: assert property ($rose(irq_n_oe_o)
        |-> $past(status_o) != $past(status_o, 2))
        else $error("irq without status change");
    chk_sync_out: assert property (!$past(rst_i) &&
        $past(sync_out_enable_i) |-> video_output_bus_o[HS_BIT] ==
        $past(hsync_i) && video_output_bus_o[VS_BIT] == $past(vsync_i))
        else $error("sync bits wrong");
    chk_plain_out: assert property (!$past(rst_i) &&
        !$past(sync_out_enable_i) |-> video_output_bus_o ==
        $past(video_data_i)) else $error("video data wrong");
    chk_addr_map: assert property (($stable(target_address_strap_i) &&
        target_address_strap_i != 2'h3)[*4] |-> target_address_o ==
        (target_address_strap_i == STRAP_CORE ? ADDR_CORE :
        target_address_strap_i == STRAP_GND ? ADDR_GND : ADDR_SDA))
        else $error("address wrong");
    chk_clk_div: assert property (async_mode_i[*3] |->
        video_output_clock_o != $past(video_output_clock_o))
        else $error("output clock not halved");
    cover property (auto && input_two_routed_o);
    cover property ($fell(irq_n_oe_o));
    cover property (sync_out_enable_i && hsync_i);
endmodule : vis_top_props
bind vis_top vis_top_props i_vis_top_props (.clk_i(clk_i), .rst_i(rst_i),
    .input_choice_field_i(input_choice_field_i),
    .auto_input_choice_enable_i(auto_input_choice_enable_i),
    .status_read_i(status_read_i), .sync_out_enable_i(sync_out_enable_i),
    .async_mode_i(async_mode_i),
    .target_address_strap_i(target_address_strap_i),
    .video_data_i(video_data_i), .hsync_i(hsync_i), .vsync_i(vsync_i),
    .status_o(status_o), .input_two_routed_o(input_two_routed_o),
    .irq_n_oe_o(irq_n_oe_o), .target_address_o(target_address_o),
    .video_output_bus_o(video_output_bus_o),
    .video_output_clock_o(video_output_clock_o));

// ==== testbench/vis_top_test.sv ====
// Self-checking bench of the input select block
`timescale 1ns/10ps
module vis_top_test;
    import vis_pkg::*;
    logic clk_i = 0, rst_i = 1, on1 = 0, on2 = 0, s1, s2, fld = 0, au = 0;
    logic msk = 0, rd = 0, syn = 0, asy = 0, nt = 0, hs = 0, vs = 0, x;
    logic two, io, ioe, ck, se, lk;
    logic [1:0] strap = 2'h0;
    logic [9:0] adc, vd = 10'h000, bus;
    logic [3:0] st;
    logic [6:0] addr;
    logic slp = 0, plk = 1, lc = 0;
    int bad_count = 0, tests_run = 0;
    vis_src_model i_vis_src_model (.clk_i(clk_i), .on1_i(on1), .on2_i(on2),
        .routed_two_i(two), .sleep_i(slp), .slc1_o(s1), .slc2_o(s2),
        .adc_o(adc));
    vis_top i_vis_top (.clk_i(clk_i), .rst_i(rst_i),
        .video_input_one_slicer_i(s1), .video_input_two_slicer_i(s2),
        .adc_sample_i(adc), .sleep_i(slp), .input_choice_field_i(fld),
        .auto_input_choice_enable_i(au), .irq_mask_i(msk),
        .status_read_i(rd), .sync_out_enable_i(syn), .async_mode_i(asy),
        .clk_source_i(CLK_XTAL27), .pll_locked_i(plk), .std_ntsc_i(nt),
        .target_address_strap_i(strap), .video_data_i(vd), .hsync_i(hs),
        .vsync_i(vs), .line_clk_i(lc), .status_o(st),
        .input_two_routed_o(two), .irq_n_out_o(io), .irq_n_oe_o(ioe),
        .target_address_o(addr), .video_output_bus_o(bus),
        .video_output_clock_o(ck), .sample_enable_o(se),
        .clock_locked_o(lk));
    initial begin
        forever #12.5 clk_i = !clk_i;
    end
    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task finish_test;
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    task rd_st;
        rd = 1;
        cyc(1);
        rd = 0;
    endtask : rd_st
    task t_strap;
        logic [6:0] exp [3];
        exp = '{ADDR_CORE, ADDR_GND, ADDR_SDA};
        for (int i = 0; i < 3; i++) begin
            strap = i[1:0];
            cyc(5);
            chk(addr, exp[i]);
        end
    endtask : t_strap
    task t_manual;
        fld = 1;
        cyc(4);
        chk(two, 1);
        chk(st[ST_SEL], 1);
        fld = 0;
        cyc(4);
        chk(two, 0);
    endtask : t_manual
    task t_irq;
        rd_st;
        cyc(4);
        chk(ioe, 0);
        nt = 1;
        cyc(4);
        chk(ioe, 1);
        chk(io, 0);
        chk(st[ST_NTSC], 1);
        nt = 0;
        cyc(4);
        chk(ioe, 1);
        rd_st;
        cyc(3);
        chk(ioe, 0);
        msk = 1;
        nt = 1;
        cyc(4);
        chk(ioe, 0);
        msk = 0;
    endtask : t_irq
    task t_fmt;
        vd = 10'h2A5;
        cyc(2);
        chk(bus, 10'h2A5);
        syn = 1;
        hs = 1;
        cyc(2);
        chk(bus[HS_BIT], 1);
        chk(bus[VS_BIT], 0);
        syn = 0;
        asy = 1;
        cyc(3);
        x = ck;
        cyc(1);
        chk(ck, !x);
        asy = 0;
        lc = 1;
        cyc(4);
        chk(ck, 1);
        lc = 0;
        cyc(4);
        chk(ck, 0);
        plk = 0;
        cyc(2);
        chk(lk, 0);
        plk = 1;
        cyc(2);
        chk(lk, 1);
        chk(se, 1);
    endtask : t_fmt
    task t_sleep;
        slp = 1;
        on1 = 1;
        on2 = 1;
        cyc(40);
        chk(st[ST_ACT1], 1);
        chk(st[ST_ACT2], 1);
        chk(two, 0);
        on1 = 0;
        on2 = 0;
        slp = 0;
        cyc(300);
        chk(st[ST_ACT1], 0);
        chk(st[ST_ACT2], 0);
    endtask : t_sleep
    task t_auto;
        au = 1;
        fld = 1;
        cyc(300);
        chk(two, 0);
        on2 = 1;
        cyc(40);
        chk(two, 1);
        chk(st[ST_ACT2], 1);
        on1 = 1;
        cyc(40);
        chk(st[ST_ACT1], 1);
        chk(two, 1);
        on2 = 0;
        cyc(300);
        chk(two, 0);
        au = 0;
        fld = 0;
    endtask : t_auto
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        finish_test;
    end
    initial begin
        cyc(4);
        rst_i = 0;
        cyc(2);
        t_strap;
        t_manual;
        t_irq;
        t_fmt;
        t_sleep;
        t_auto;
        finish_test;
    end
endmodule : vis_top_test
